/* File: src/dpc_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module dpc_counter
  import dpc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        pin_a,
  input  wire logic        pin_b,
  input  wire logic        pin_ctl_reset,
  input  wire logic        pin_ctl_lockout,
  input  wire logic        key_front_reset,
  input  wire logic        key_scroll,
  input  wire logic        key_any,
  input  wire logic        param_enter,
  input  wire logic        edit_request,
  input  wire logic        op_mode_count_shown,
  input  wire dpc_cfg_t    cfg_in,
  input  wire logic        cfg_load,
  input  wire dpc_preset_t preset_in,
  input  wire logic        preset_wr,
  output logic [16:0]      count_value,
  output logic             out2_active,
  output logic             out2_relay_on,
  output logic             color_green,
  output logic             op1_led,
  output logic             op2_led,
  output logic             show_name,
  output logic             show_value,
  output logic             edit_allowed,
  output logic             serial_params_shown,
  output logic [6:0]       station_addr,
  output dpc_baud_t        baud_sel,
  output logic [16:0]      preset2_value,
  output logic             lockout
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else begin
      sync1_reg <= {key_front_reset, pin_ctl_lockout, pin_b, pin_a};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end
  wire a_s    = sync2_reg[0];
  wire b_s    = sync2_reg[1];
  wire a_rise = sync2_reg[0] & ~prev_reg[0];
  wire b_rise = sync2_reg[1] & ~prev_reg[1];
  wire key_rise = sync2_reg[3] & ~prev_reg[3];

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  dpc_cfg_t cfg_reg;
  wire addr_ok = (cfg_in.station_addr >= ADDR_MIN) && (cfg_in.station_addr <= ADDR_MAX);
  wire time_ok = cfg_in.out2_time <= OUT2_T_MAX;
  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      cfg_reg <= CFG_DEF;
    else if (cfg_load && addr_ok && time_ok)
      cfg_reg <= cfg_in;
  end

  // ----------------------------------------------------------------
  // Control inputs: 25 ms qualification; remote reset acts on the rising edge, lockout follows the level
  // ----------------------------------------------------------------
  localparam int CW = $clog2(CTRL_CYC + 1);
  logic [CW-1:0] rst_cnt_reg;
  logic [CW-1:0] lok_cnt_reg;
  logic          rst_lvl_reg;
  logic          rst_prev_reg;
  logic          rst_s1_reg;
  logic          rst_s2_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rst_s1_reg   <= 1'b0;
      rst_s2_reg   <= 1'b0;
      rst_cnt_reg  <= '0;
      lok_cnt_reg  <= '0;
      rst_lvl_reg  <= 1'b0;
      rst_prev_reg <= 1'b0;
    end else begin
      rst_s1_reg   <= pin_ctl_reset;
      rst_s2_reg   <= rst_s1_reg;
      rst_prev_reg <= rst_lvl_reg;
      if (rst_s2_reg == rst_lvl_reg)
        rst_cnt_reg <= '0;
      else if (rst_cnt_reg == CW'(CTRL_CYC - 1)) begin
        rst_cnt_reg <= '0;
        rst_lvl_reg <= rst_s2_reg;
      end else
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      if (sync2_reg[2] == lockout)
        lok_cnt_reg <= '0;
      else if (lok_cnt_reg == CW'(CTRL_CYC - 1))
        lok_cnt_reg <= '0;
      else
        lok_cnt_reg <= lok_cnt_reg + 1'b1;
    end
  end
  wire remote_rst = rst_lvl_reg & ~rst_prev_reg;
  wire lok_flip   = (sync2_reg[2] != lockout) && (lok_cnt_reg == CW'(CTRL_CYC - 1));

  // ----------------------------------------------------------------
  // Count engine
  // ----------------------------------------------------------------
  logic [1:0] qd;
  always_comb begin
    qd = 2'b00;
    case (cfg_reg.count_mode)
      DPC_CM_SUM:  qd = {1'b0, a_rise ^ b_rise} | {a_rise & b_rise, 1'b0};
      DPC_CM_DIFF: qd = (a_rise & ~b_rise) ? 2'b01 : ((b_rise & ~a_rise) ? 2'b11 : 2'b00);
      DPC_CM_DIR:  qd = a_rise ? (b_s ? 2'b11 : 2'b01) : 2'b00;
      DPC_CM_QUAD: qd = (a_rise & ~b_s) ? 2'b01 : ((b_rise & ~a_s) ? 2'b11 : 2'b00);
      default:     qd = 2'b00;
    endcase
  end
  // qd: 01 = +1, 10 = +2, 11 = -1
  wire front_clr = cfg_reg.front_rst_en & key_rise & op_mode_count_shown;
  wire clr       = remote_rst | front_clr;
  logic [16:0] count_next;
  always_comb begin
    count_next = count_value;
    if (clr)
      count_next = 17'h0;
    else if (qd == 2'b11)
      count_next = (count_value == 17'h0) ? COUNT_MAX : count_value - 17'h1;
    else if (qd != 2'b00)
      count_next = (count_value + {15'h0, qd} > COUNT_MAX) ?
                   count_value + {15'h0, qd} - COUNT_MAX - 17'h1 : count_value + {15'h0, qd};
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      count_value <= 17'h0;
    else
      count_value <= count_next;
  end

  // ----------------------------------------------------------------
  // Preset 2 and output 2 timing
  // ----------------------------------------------------------------
  localparam int TW = $clog2(TICK_10MS_CYC);
  logic [TW-1:0] tick_cnt_reg;
  logic [13:0]   o2_cnt_reg;
  logic          p2_hit_reg;
  logic          o1_reg;
  wire tick   = tick_cnt_reg == TW'(TICK_10MS_CYC - 1);
  wire p2_now = count_value >= preset2_value;
  wire p2_new = p2_now & ~p2_hit_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tick_cnt_reg  <= '0;
      o2_cnt_reg    <= 14'h0;
      p2_hit_reg    <= 1'b0;
      out2_active   <= 1'b0;
      preset2_value <= PRESET2_DEF;
      o1_reg        <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      p2_hit_reg   <= p2_now;
      o1_reg       <= preset_in.preset1_hit;
      if (preset_wr && edit_allowed)
        preset2_value <= preset_in.preset2;
      if (clr) begin
        out2_active <= 1'b0;
        o2_cnt_reg  <= 14'h0;
      end else if (p2_new) begin
        out2_active <= 1'b1;
        o2_cnt_reg  <= cfg_reg.out2_time;
      end else if (out2_active && cfg_reg.out2_time != 14'h0 && tick) begin
        if (o2_cnt_reg <= 14'h1)
          out2_active <= 1'b0;
        o2_cnt_reg <= o2_cnt_reg - 14'h1;
      end
    end
  end

  // Relay pull-in is mechanical; the drive follows the transistor one clock later
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      out2_relay_on <= 1'b0;
      op1_led       <= 1'b0;
      op2_led       <= 1'b0;
    end else begin
      out2_relay_on <= out2_active;
      op1_led       <= o1_reg;
      op2_led       <= out2_active;
    end
  end

  // ----------------------------------------------------------------
  // Display colour
  // ----------------------------------------------------------------
  logic green_next;
  always_comb begin
    case (cfg_reg.color)
      DPC_COL_RED: green_next = 1'b0;
      DPC_COL_GRN: green_next = 1'b1;
      DPC_COL_G2R: green_next = ~p2_hit_reg;
      DPC_COL_R2G: green_next = p2_hit_reg;
      default:     green_next = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Help prompt
  // ----------------------------------------------------------------
  localparam int HW = $clog2(HELP_TICKS + 1);
  dpc_help_t     hs_reg;
  dpc_help_t     hs_next;
  logic [HW-1:0] help_cnt_reg;
  always_comb begin
    hs_next = hs_reg;
    case (hs_reg)
      DPC_HS_IDLE:  hs_next = param_enter ? (cfg_reg.help_on ? DPC_HS_NAME : DPC_HS_VALUE) : DPC_HS_IDLE;
      DPC_HS_NAME:  hs_next = (key_scroll || help_cnt_reg == HW'(HELP_TICKS)) ? DPC_HS_VALUE : DPC_HS_NAME;
      DPC_HS_VALUE: hs_next = param_enter ? (cfg_reg.help_on ? DPC_HS_NAME : DPC_HS_VALUE) : DPC_HS_VALUE;
      default:      hs_next = DPC_HS_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hs_reg       <= DPC_HS_IDLE;
      help_cnt_reg <= '0;
    end else begin
      hs_reg <= hs_next;
      if (key_any || hs_next != hs_reg)
        help_cnt_reg <= '0;
      else if (tick && help_cnt_reg != HW'(HELP_TICKS))
        help_cnt_reg <= help_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      color_green         <= 1'b1;
      show_name           <= 1'b0;
      show_value          <= 1'b0;
      edit_allowed        <= 1'b1;
      serial_params_shown <= 1'b0;
      station_addr        <= ADDR_DEF;
      baud_sel            <= DPC_BAUD_4800;
      lockout             <= 1'b0;
    end else begin
      color_green         <= green_next;
      show_name           <= hs_next == DPC_HS_NAME;
      show_value          <= hs_next == DPC_HS_VALUE;
      edit_allowed        <= ~cfg_reg.preset_lock & ~lockout;
      serial_params_shown <= cfg_reg.serial_en;
      station_addr        <= cfg_reg.station_addr;
      // The serial board frames each character itself at the rate handed over here
      baud_sel            <= cfg_reg.baud;
      if (lok_flip)
        lockout <= ~lockout;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rng;
    @(posedge clk_sys) disable iff (!rst_b) count_value <= COUNT_MAX;
  endproperty
  a_rng: assert property (p_rng) else $error("count above range");

  property p_fclr;
    @(posedge clk_sys) disable iff (!rst_b) front_clr |=> count_value == 17'h0;
  endproperty
  a_fclr: assert property (p_fclr) else $error("front reset did not clear");

  property p_fdis;
    @(posedge clk_sys) disable iff (!rst_b)
      (!cfg_reg.front_rst_en && !remote_rst && qd == 2'b00 && count_value != 17'h0) |=> count_value != 17'h0;
  endproperty
  a_fdis: assert property (p_fdis) else $error("count cleared with front reset off");

  property p_o2on;
    @(posedge clk_sys) disable iff (!rst_b) (p2_new && !clr) |=> out2_active ##1 out2_relay_on;
  endproperty
  a_o2on: assert property (p_o2on) else $error("output 2 late");

  property p_latch;
    @(posedge clk_sys) disable iff (!rst_b)
      (out2_active && cfg_reg.out2_time == 14'h0 && !clr && !cfg_load) |=> out2_active;
  endproperty
  a_latch: assert property (p_latch) else $error("latched output dropped");

  property p_col;
    @(posedge clk_sys) disable iff (!rst_b) (cfg_reg.color == DPC_COL_G2R) |=> color_green == !$past(p2_hit_reg);
  endproperty
  a_col: assert property (p_col) else $error("colour wrong");

  property p_lock;
    @(posedge clk_sys) disable iff (!rst_b) cfg_reg.preset_lock |=> !edit_allowed;
  endproperty
  a_lock: assert property (p_lock) else $error("edit allowed under lock");

  sequence s_name;
    hs_reg == DPC_HS_NAME && key_scroll;
  endsequence
  property p_help;
    @(posedge clk_sys) disable iff (!rst_b) s_name |=> show_value;
  endproperty
  a_help: assert property (p_help) else $error("scroll did not show value");

  property p_addr;
    @(posedge clk_sys) disable iff (!rst_b) ##1 (station_addr >= ADDR_MIN && station_addr <= ADDR_MAX);
  endproperty
  a_addr: assert property (p_addr) else $error("address out of range");

endmodule
`default_nettype wire

/* File: src/dpc_pkg.sv */
package dpc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 125000000;
  localparam int TICK_10MS_CYC    = CLK_HZ / 100;
  localparam int HELP_TIME_S      = 3;
  localparam int HELP_TICKS       = HELP_TIME_S * 100;
  localparam int CTRL_RESP_MS     = 25;
  localparam int CTRL_CYC         = CTRL_RESP_MS * (CLK_HZ / 1000);
  localparam int OUT_LAT_US       = 75;
  localparam int OUT_LAT_CYC      = OUT_LAT_US * (CLK_HZ / 1000000);
  localparam int RELAY_PULL_MS    = 8;
  localparam int RELAY_CYC        = RELAY_PULL_MS * (CLK_HZ / 1000);
  localparam int MAX_RATE_HZ      = 10000;

  // ----------------------------------------------------------------
  // Limits and reset values
  // ----------------------------------------------------------------
  localparam logic [16:0] COUNT_MAX    = 17'h1869f;
  localparam logic [16:0] PRESET2_DEF  = 17'h0000a;
  localparam logic [13:0] OUT2_T_MAX   = 14'h270f;
  localparam logic [13:0] OUT2_T_DEF   = 14'h0064;
  localparam logic [6:0]  ADDR_MIN     = 7'h01;
  localparam logic [6:0]  ADDR_MAX     = 7'h63;
  localparam logic [6:0]  ADDR_DEF     = 7'h01;
  localparam int          FRAME_BITS   = 10;
  localparam int          DATA_BITS    = 7;

  typedef enum logic [1:0] {
    DPC_BAUD_1200 = 2'b00,
    DPC_BAUD_2400 = 2'b01,
    DPC_BAUD_4800 = 2'b10,
    DPC_BAUD_9600 = 2'b11
  } dpc_baud_t;

  typedef enum logic [1:0] {
    DPC_COL_RED = 2'b00,
    DPC_COL_GRN = 2'b01,
    DPC_COL_G2R = 2'b10,
    DPC_COL_R2G = 2'b11
  } dpc_color_t;

  typedef enum logic [1:0] {
    DPC_CM_SUM  = 2'b00,
    DPC_CM_DIFF = 2'b01,
    DPC_CM_DIR  = 2'b10,
    DPC_CM_QUAD = 2'b11
  } dpc_cmode_t;

  typedef enum logic [1:0] {
    DPC_HS_NAME  = 2'b00,
    DPC_HS_VALUE = 2'b01,
    DPC_HS_IDLE  = 2'b10
  } dpc_help_t;

  typedef struct packed {
    logic [13:0] out2_time;
    logic        front_rst_en;
    logic        serial_en;
    logic [6:0]  station_addr;
    dpc_baud_t   baud;
    dpc_color_t  color;
    logic        preset_lock;
    logic        help_on;
    dpc_cmode_t  count_mode;
  } dpc_cfg_t;

  localparam dpc_cfg_t CFG_DEF = '{
    out2_time:    OUT2_T_DEF,
    front_rst_en: 1'b1,
    serial_en:    1'b0,
    station_addr: ADDR_DEF,
    baud:         DPC_BAUD_4800,
    color:        DPC_COL_G2R,
    preset_lock:  1'b0,
    help_on:      1'b1,
    count_mode:   DPC_CM_SUM
  };

  typedef struct packed {
    logic [16:0] preset2;
    logic        preset1_hit;
  } dpc_preset_t;

endpackage

/* File: dv/dpc_pulse_src.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Count channel source: contact or encoder pulses
// ------------------------------------------------------------
module dpc_pulse_src
  import dpc_pkg::*;
#(
  parameter int HALF_CYC = CLK_HZ / MAX_RATE_HZ / 2
)(
  input  wire logic clk_sys,
  output var logic  pin_a,
  output var logic  pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // Levels change only at falling edges and stand for a whole step
  task automatic level(input logic a, input logic b, input int n);
    @(negedge clk_sys);
    pin_a = a;
    pin_b = b;
    repeat (n - 1) @(negedge clk_sys);
  endtask

  // A full period per channel is never shorter than the rate limit allows
  task automatic pulse(input logic a, input logic b);
    level(a, b, HALF_CYC);
    level(1'b0, 1'b0, HALF_CYC);
  endtask

  // Encoder step with A leading B; quarter steps keep each channel at the limit
  task automatic quad_step();
    level(1'b1, 1'b0, HALF_CYC / 2);
    level(1'b1, 1'b1, HALF_CYC / 2);
    level(1'b0, 1'b1, HALF_CYC / 2);
    level(1'b0, 1'b0, HALF_CYC / 2);
  endtask
endmodule
`default_nettype wire

/* File: dv/dpc_counter_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module dpc_counter_bench
  import dpc_pkg::*;
;
  logic clk_sys, rst_b, pin_a, pin_b, pin_ctl_reset, pin_ctl_lockout, key_front_reset;
  logic key_scroll, key_any, param_enter, edit_request, op_mode_count_shown, cfg_load, preset_wr;
  logic out2_active, out2_relay_on, color_green, op1_led, op2_led, show_name, show_value;
  logic edit_allowed, serial_params_shown, lockout;
  logic [16:0] count_value, preset2_value, last_cnt, exp_cnt;
  logic [6:0]  station_addr, prev_addr, try_addr;
  dpc_baud_t   baud_sel;
  dpc_cfg_t    cfg_in, c;
  dpc_preset_t preset_in;
  logic [16:0] cnt_q[$];
  int          failures, checks, cyc;

  always #4 clk_sys = ~clk_sys;

  dpc_pulse_src src (.clk_sys(clk_sys), .pin_a(pin_a), .pin_b(pin_b));

  dpc_counter dut (.clk_sys(clk_sys), .rst_b(rst_b), .pin_a(pin_a), .pin_b(pin_b),
    .pin_ctl_reset(pin_ctl_reset), .pin_ctl_lockout(pin_ctl_lockout), .key_front_reset(key_front_reset),
    .key_scroll(key_scroll), .key_any(key_any), .param_enter(param_enter), .edit_request(edit_request),
    .op_mode_count_shown(op_mode_count_shown), .cfg_in(cfg_in), .cfg_load(cfg_load),
    .preset_in(preset_in), .preset_wr(preset_wr), .count_value(count_value), .out2_active(out2_active),
    .out2_relay_on(out2_relay_on), .color_green(color_green), .op1_led(op1_led), .op2_led(op2_led),
    .show_name(show_name), .show_value(show_value), .edit_allowed(edit_allowed),
    .serial_params_shown(serial_params_shown), .station_addr(station_addr), .baud_sel(baud_sel),
    .preset2_value(preset2_value), .lockout(lockout));

  // ------------------------------------------------------------
  // Checking and verdict
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Every change of the count must match the oldest expectation
  // Sampled at the falling edge, where the registered count has settled
  always @(negedge clk_sys) begin
    cyc++;
    if (rst_b === 1'b1 && count_value !== last_cnt) begin
      if (cnt_q.size() == 0) check("unplanned count", {15'h0, count_value}, {15'h0, last_cnt});
      else check("count", {15'h0, count_value}, {15'h0, cnt_q.pop_front()});
      last_cnt = count_value;
    end
    if (cyc == 95000) begin
      failures++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Stimulus helpers
  // ------------------------------------------------------------
  task automatic load(input dpc_cfg_t v);
    @(negedge clk_sys);
    cfg_in = v;
    cfg_load = 1'b1;
    @(negedge clk_sys);
    cfg_load = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic write_p2(input logic [16:0] v);
    @(negedge clk_sys);
    preset_in = '{preset2: v, preset1_hit: 1'b0};
    preset_wr = 1'b1;
    @(negedge clk_sys);
    preset_wr = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  // Key held for many cycles must still act only once
  task automatic press(input int n);
    @(negedge clk_sys);
    key_front_reset = 1'b1;
    repeat (n) @(negedge clk_sys);
    key_front_reset = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask

  // One-cycle pulse on a same-clock input: 0 edit, 1 enter, 2 scroll, 3 any key
  task automatic strobe(input int which);
    @(negedge clk_sys);
    case (which)
      0: edit_request = 1'b1;
      1: param_enter = 1'b1;
      2: key_scroll = 1'b1;
      default: key_any = 1'b1;
    endcase
    @(negedge clk_sys);
    edit_request = 1'b0;
    param_enter = 1'b0;
    key_scroll = 1'b0;
    key_any = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  function automatic logic [16:0] step(input logic [16:0] v, input bit up);
    if (up) return (v == COUNT_MAX) ? 17'h0 : v + 17'h1;
    return (v == 17'h0) ? COUNT_MAX : v - 17'h1;
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 0; rst_b = 0; cfg_in = CFG_DEF; cfg_load = 0; preset_in = '0; preset_wr = 0;
    key_front_reset = 0; key_scroll = 0; key_any = 0; param_enter = 0; edit_request = 0;
    op_mode_count_shown = 0; pin_ctl_reset = 0; pin_ctl_lockout = 0; last_cnt = '0;
    void'($urandom(97));
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("count", {15'h0, count_value}, 32'h0);
    check("out2", {31'h0, out2_active}, 32'h0);
    check("green", {31'h0, color_green}, 32'h1);
    check("addr", {25'h0, station_addr}, {25'h0, ADDR_DEF});
    check("baud", {30'h0, baud_sel}, {30'h0, DPC_BAUD_4800});
    check("edit", {31'h0, edit_allowed}, 32'h1);
    check("serial", {31'h0, serial_params_shown}, 32'h0);
    check("lockout", {31'h0, lockout}, 32'h0);
    check("op1 led", {31'h0, op1_led}, 32'h0);
    check("frame bits", FRAME_BITS, 32'h0000000a);
    check("data bits", DATA_BITS, 32'h00000007);
    c = CFG_DEF;
    for (int i = 0; i < 4; i++) begin
      c.color = dpc_color_t'(i);
      load(c);
      check("green", {31'h0, color_green}, (i == 1 || i == 2) ? 32'h1 : 32'h0);
    end
    c.serial_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      c.baud = dpc_baud_t'(i);
      load(c);
      check("baud", {30'h0, baud_sel}, i);
      check("serial", {31'h0, serial_params_shown}, 32'h1);
    end
    prev_addr = ADDR_DEF;
    for (int i = 0; i < 5; i++) begin
      try_addr = (i == 0) ? 7'h63 : (i == 1) ? 7'h0 : (i == 2) ? 7'h64 : (i == 3) ? 7'h1 : 7'($urandom_range(1, 99));
      c.station_addr = try_addr;
      load(c);
      if (try_addr >= ADDR_MIN && try_addr <= ADDR_MAX) prev_addr = try_addr;
      check("addr", {25'h0, station_addr}, {25'h0, prev_addr});
    end
    c.preset_lock = 1'b1;
    load(c);
    strobe(0);
    check("edit", {31'h0, edit_allowed}, 32'h0);
    write_p2(17'h5);
    check("preset2", {15'h0, preset2_value}, 32'ha);
    c = CFG_DEF;
    c.out2_time = 14'h0;
    load(c);
    write_p2(17'h2);
    check("preset2", {15'h0, preset2_value}, 32'h2);
    // Both channels at once add two and reach the preset
    exp_cnt = 17'h2;
    cnt_q.push_back(exp_cnt);
    src.pulse(1'b1, 1'b1);
    check("out2", {31'h0, out2_active}, 32'h1);
    check("relay", {31'h0, out2_relay_on}, 32'h1);
    check("op2 led", {31'h0, op2_led}, 32'h1);
    check("green", {31'h0, color_green}, 32'h0);
    preset_in.preset1_hit = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("op1 led", {31'h0, op1_led}, 32'h1);
    repeat (300) @(negedge clk_sys);
    check("latched out2", {31'h0, out2_active}, 32'h1);
    c.front_rst_en = 1'b0;
    load(c);
    op_mode_count_shown = 1'b1;
    press(20);
    c.front_rst_en = 1'b1;
    load(c);
    op_mode_count_shown = 1'b0;
    press(20);
    op_mode_count_shown = 1'b1;
    exp_cnt = 17'h0;
    cnt_q.push_back(exp_cnt);
    press(200);
    c.count_mode = DPC_CM_DIFF;
    load(c);
    exp_cnt = step(exp_cnt, 0);
    cnt_q.push_back(exp_cnt);
    src.pulse(1'b0, 1'b1);
    exp_cnt = step(exp_cnt, 1);
    cnt_q.push_back(exp_cnt);
    src.pulse(1'b1, 1'b0);
    c.count_mode = DPC_CM_DIR;
    load(c);
    exp_cnt = step(exp_cnt, 0);
    cnt_q.push_back(exp_cnt);
    src.level(1'b0, 1'b1, src.HALF_CYC);
    src.pulse(1'b1, 1'b1);
    c.count_mode = DPC_CM_QUAD;
    load(c);
    exp_cnt = step(exp_cnt, 1);
    cnt_q.push_back(exp_cnt);
    src.quad_step();
    strobe(1);
    check("name", {31'h0, show_name}, 32'h1);
    strobe(2);
    strobe(3);
    check("value", {31'h0, show_value}, 32'h1);
    c.help_on = 1'b0;
    load(c);
    strobe(1);
    check("name", {31'h0, show_name}, 32'h0);
    check("value", {31'h0, show_value}, 32'h1);
    repeat (10) @(negedge clk_sys);
    check("pending", cnt_q.size(), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
